// file: mcs_host_model.sv
// host terminal model: issues register write and query commands
module mcs_host_model (
  input  wire logic       clk,
  output logic            cmd_wr,
  output logic            cmd_rd,
  output logic [7:0]      cmd_reg,
  output logic [7:0]      cmd_wdata,
  input  wire logic       cmd_rvalid,
  input  wire logic       cmd_rerr,
  input  wire logic [7:0] cmd_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_reg = 8'h00;
    cmd_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] r, input logic [7:0] v, output logic err);
    @(negedge clk);
    cmd_reg = r;
    cmd_wdata = v;
    cmd_wr = 1'b1;
    @(negedge clk);
    cmd_wr = 1'b0;
    cmd_wdata = ~v;
    err = cmd_rerr;
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] d, output logic err);
    @(negedge clk);
    cmd_reg = r;
    cmd_rd = 1'b1;
    @(negedge clk);
    cmd_rd = 1'b0;
    d = cmd_rdata;
    err = cmd_rerr | ~cmd_rvalid;
  endtask
endmodule // mcs_host_model

// file: mcs_pkg.sv
// package: register indices, field layout, reset values and timing for the modem config bank
package mcs_pkg;
  // ----------------------------------------
  // register numbers used by the query command
  // ----------------------------------------
  localparam logic [7:0] REG_FAIL_CAUSE  = 8'h56;
  localparam logic [7:0] REG_HIGH_BAUD   = 8'h57;
  localparam logic [7:0] REG_MI_OPTIONS  = 8'h5c;
  localparam logic [7:0] REG_CALL_SPEED  = 8'h5d;
  localparam logic [7:0] REG_START_MODE  = 8'h5e;
  localparam logic [7:0] REG_NEG_MSG     = 8'h5f;
  localparam logic [7:0] REG_PROBE_TIME  = 8'h61;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_FAIL_CAUSE  = 8'h00;
  localparam logic [7:0] RST_HIGH_BAUD   = 8'h0e;
  localparam logic [7:0] RST_MI_OPTIONS  = 8'h00;
  localparam logic [7:0] RST_CALL_SPEED  = 8'h09;
  localparam logic [7:0] RST_START_MODE  = 8'h00;
  localparam logic [7:0] RST_NEG_MSG     = 8'h00;
  localparam logic [7:0] RST_PROBE_TIME  = 8'h1e;
  // ----------------------------------------
  // failure cause codes
  // ----------------------------------------
  localparam logic [7:0] CAUSE_NORMAL    = 8'h00;
  localparam logic [7:0] CAUSE_NO_SYNC   = 8'h0b;
  localparam logic [7:0] CAUSE_NO_REPLY  = 8'h0d;
  localparam logic [3:0] RETRY_LIMIT     = 4'ha;
  // ----------------------------------------
  // speed codes (callsetup speed table)
  // ----------------------------------------
  localparam logic [7:0] HIGH_SEL_19200  = 8'h0e;
  localparam logic [7:0] HIGH_SEL_38400  = 8'h1c;
  localparam logic [3:0] SPD_9600        = 4'h9;
  localparam logic [3:0] SPD_19200       = 4'hc;
  localparam logic [3:0] SPD_38400       = 4'hd;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int MI_EN_BIT      = 0;
  localparam int MI_EDGE_BIT    = 1;
  localparam int MI_ANSWER_BIT  = 2;
  localparam int MI_RING_OFF_BIT = 3;
  localparam int SM_DIRECT_BIT  = 2;
  localparam int SM_EBCDIC_BIT  = 3;
  localparam int NEG_MSG_BITS   = 6;
  // ----------------------------------------
  // probe timing limits, tenths of a second
  // ----------------------------------------
  localparam logic [7:0] PROBE_MIN       = 8'h0f;
  localparam logic [7:0] PROBE_MAX       = 8'h46;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint CLK_HZ           = 64'd50000000;
  localparam longint NO_SYNC_SECONDS  = 64'd30;
  localparam longint NO_SYNC_CYCLES   = NO_SYNC_SECONDS * CLK_HZ;
  localparam longint PROBE_UNIT_MS    = 64'd100;
  localparam longint PROBE_UNIT_CYCLES = PROBE_UNIT_MS * CLK_HZ / 64'd1000;
endpackage : mcs_pkg

// file: mcs_regs.sv
// module: modem configuration and status register bank
// Summary of operation
// [RULE_01] on a no-carrier report, write the failure cause into the cause register
// [RULE_02] cause codes: 0 normal, 4 carrier loss, 5-10 negotiation, 12 remote, 14, 15
// [RULE_03] no synchronous data or flags for 30 seconds: hang up, cause 11
// [RULE_04] ten unanswered transmissions of one message: hang up, cause 13
// [RULE_05] several failure events: keep the earliest cause, ignore later ones
// [RULE_06] speeds to 9600 always accepted; 14 adds 19200, 28 adds 38400
// [RULE_07] autobaud takes speed from first prefix character, maybe the second
// [RULE_08] mode-indicate: 0 off, odd on, +2 edge, +4 answer, +8 no ring pulse
// [RULE_09] nonzero mode-indicate value overrides the jack command setting
// [RULE_10] callsetup mode runs terminal at callsetup speed code 3 to 13
// [RULE_11] autobaud outside callsetup mode uses the carrier speed select value
// [RULE_12] standard switch setting: soft reset takes mode from startup mode register
// [RULE_13] startup mode loads from nonvolatile memory at power-on, store saves it
// [RULE_14] startup low bits: async standard, async callsetup, sync hdlc, sync bsc
// [RULE_15] +4 selects direct calling, +8 selects ebcdic for synchronous modes
// [RULE_16] negotiation messages only add result codes; factory value zero
// [RULE_17] bits: line speed, error control suffix, carrier, protocol, autostream, compression
// [RULE_18] set bits enable codes regardless of result message command
// [RULE_19] answer automode: send probe for timing register tenths, 1.5 to 7.0 s
// [RULE_20] originate automode: reject probe for timing register duration
// [RULE_21] probe timing defaults to 30, three seconds
// [RULE_22] each register eight bits, readable through the query command
module mcs_regs #(
  parameter longint NO_SYNC_CYCLES_P = mcs_pkg::NO_SYNC_CYCLES,
  parameter longint PROBE_UNIT_P     = mcs_pkg::PROBE_UNIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [7:0]  cmd_reg,
  input  wire logic [7:0]  cmd_wdata,
  output logic             cmd_rvalid,
  output logic             cmd_rerr,
  output logic [7:0]       cmd_rdata,
  input  wire logic        call_start,
  input  wire logic        fail_event,
  input  wire logic [7:0]  fail_code,
  input  wire logic        sync_activity,
  input  wire logic        msg_retransmit,
  input  wire logic        msg_acked,
  output logic             no_carrier,
  output logic             hang_up,
  input  wire logic        autobaud_start,
  input  wire logic        prefix_char,
  input  wire logic [3:0]  prefix_speed,
  input  wire logic        prefix_ambiguous,
  input  wire logic [7:0]  carrier_speed_select,
  output logic [3:0]       dte_speed,
  output logic             dte_speed_valid,
  output logic             mi_enable,
  output logic             mi_edge,
  output logic             mi_answer,
  output logic             ring_indicator_pulse_off,
  output logic             jack_override,
  input  wire logic        std_switch_pin,
  input  wire logic        soft_reset,
  input  wire logic        nv_load,
  input  wire logic [7:0]  nv_rdata,
  input  wire logic        store_profile,
  output logic             nv_store,
  output logic [7:0]       nv_wdata,
  output logic [1:0]       op_base_mode,
  output logic             op_direct,
  output logic             op_ebcdic,
  input  wire logic [5:0]  result_message_command_mask,
  output logic [5:0]       result_enables,
  input  wire logic        probe_start,
  input  wire logic        answer_mode,
  output logic             probe_send,
  output logic             probe_reject
);
  import mcs_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  fail_cause;
    logic        fail_held;
    logic [7:0]  high_baud;
    logic [7:0]  mi_opts;
    logic [7:0]  call_speed;
    logic [7:0]  start_mode;
    logic [7:0]  neg_msg;
    logic [7:0]  probe_time;
    logic        rvalid;
    logic        rerr;
    logic [7:0]  rdata;
    logic        in_call;
    logic [31:0] sync_cnt;
    logic [3:0]  retry_cnt;
    logic        no_carrier;
    logic        hang_up;
    logic [1:0]  baud_phase;
    logic [3:0]  dte_speed;
    logic        dte_valid;
    logic        sw_meta;
    logic        sw_sync;
    logic [1:0]  op_base;
    logic        op_direct;
    logic        op_ebcdic;
    logic        nv_store;
    logic [7:0]  nv_wdata;
    logic [5:0]  result_en;
    logic        mi_en;
    logic        mi_edge;
    logic        mi_answer;
    logic        ring_off;
    logic        jack_ovr;
    logic [7:0]  probe_ticks;
    logic [31:0] unit_cnt;
    logic        probe_send;
    logic        probe_reject;
  } mcs_state_s;

  mcs_state_s st_reg;
  mcs_state_s st_next;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic [3:0] mcs_high_speed(input logic [7:0] sel);
    case (sel)
      HIGH_SEL_19200: mcs_high_speed = SPD_19200;
      HIGH_SEL_38400: mcs_high_speed = SPD_38400;
      default:        mcs_high_speed = SPD_9600;
    endcase
  endfunction

  function automatic logic mcs_speed_ok(input logic [3:0] spd, input logic [7:0] sel);
    mcs_speed_ok = (spd <= SPD_9600) || (spd == mcs_high_speed(sel));
  endfunction

  function automatic logic [7:0] mcs_probe_clamp(input logic [7:0] v);
    if (v < PROBE_MIN) begin
      mcs_probe_clamp = PROBE_MIN;
    end else if (v > PROBE_MAX) begin
      mcs_probe_clamp = PROBE_MAX;
    end else begin
      mcs_probe_clamp = v;
    end
  endfunction

  localparam logic [31:0] SYNC_LAST = 32'(NO_SYNC_CYCLES_P - 64'd1);
  localparam logic [31:0] UNIT_LAST = 32'(PROBE_UNIT_P - 64'd1);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic       fail_now;
    logic [7:0] fail_val;
    logic       wr_hit;
    logic       base_callsetup;
    fail_now       = 1'b0;
    fail_val       = CAUSE_NORMAL;
    wr_hit         = 1'b0;
    base_callsetup = 1'b0;
    st_next = st_reg;
    st_next.rvalid     = 1'b0;
    st_next.rerr       = 1'b0;
    st_next.no_carrier = 1'b0;
    st_next.hang_up    = 1'b0;
    st_next.nv_store   = 1'b0;
    st_next.dte_valid  = 1'b0;

    // pin synchroniser for the command-mode switch
    st_next.sw_meta = std_switch_pin;
    st_next.sw_sync = st_reg.sw_meta;

    // host register writes
    if (cmd_wr) begin
      wr_hit = 1'b1;
      case (cmd_reg)
        REG_HIGH_BAUD:  st_next.high_baud  = cmd_wdata; // RULE_06
        REG_MI_OPTIONS: st_next.mi_opts    = cmd_wdata;
        REG_CALL_SPEED: st_next.call_speed = cmd_wdata;
        REG_START_MODE: st_next.start_mode = cmd_wdata;
        REG_NEG_MSG:    st_next.neg_msg    = cmd_wdata; // RULE_18
        REG_PROBE_TIME: st_next.probe_time = cmd_wdata;
        default:        wr_hit = 1'b0;
      endcase
      st_next.rerr = ~wr_hit;
    end

    // host register reads
    if (cmd_rd) begin
      st_next.rvalid = 1'b1;
      case (cmd_reg) // RULE_22
        REG_FAIL_CAUSE: st_next.rdata = st_reg.fail_cause;
        REG_HIGH_BAUD:  st_next.rdata = st_reg.high_baud;
        REG_MI_OPTIONS: st_next.rdata = st_reg.mi_opts;
        REG_CALL_SPEED: st_next.rdata = st_reg.call_speed;
        REG_START_MODE: st_next.rdata = st_reg.start_mode;
        REG_NEG_MSG:    st_next.rdata = st_reg.neg_msg;
        REG_PROBE_TIME: st_next.rdata = st_reg.probe_time;
        default: begin
          st_next.rdata = 8'h00;
          st_next.rerr  = 1'b1;
        end
      endcase
    end

    // failure detection during a call
    if (call_start) begin
      st_next.in_call    = 1'b1;
      st_next.fail_held  = 1'b0;
      st_next.fail_cause = CAUSE_NORMAL;
      st_next.sync_cnt   = 32'h0;
      st_next.retry_cnt  = 4'h0;
    end else if (st_reg.in_call) begin
      if (sync_activity) begin
        st_next.sync_cnt = 32'h0;
      end else if (st_reg.sync_cnt == SYNC_LAST) begin
        fail_now = 1'b1; // RULE_03
        fail_val = CAUSE_NO_SYNC;
      end else begin
        st_next.sync_cnt = st_reg.sync_cnt + 32'h1;
      end
      if (msg_acked) begin
        st_next.retry_cnt = 4'h0;
      end else if (msg_retransmit) begin
        st_next.retry_cnt = st_reg.retry_cnt + 4'h1;
        if (st_reg.retry_cnt + 4'h1 == RETRY_LIMIT && !fail_now) begin
          fail_now = 1'b1; // RULE_04
          fail_val = CAUSE_NO_REPLY;
        end
      end
      if (fail_event) begin
        fail_now = 1'b1; // RULE_05
        fail_val = fail_code; // RULE_02
      end
      if (fail_now) begin
        st_next.in_call    = 1'b0;
        st_next.hang_up    = 1'b1;
        st_next.no_carrier = 1'b1;
        if (!st_reg.fail_held) begin
          st_next.fail_cause = fail_val; // RULE_01
          st_next.fail_held  = 1'b1; // RULE_05
        end
      end
    end

    // autobaud from the attention prefix
    if (autobaud_start) begin
      st_next.baud_phase = 2'd1;
    end else if (prefix_char && st_reg.baud_phase != 2'd0) begin
      base_callsetup = (st_reg.start_mode[1:0] != 2'd0);
      if (base_callsetup) begin
        st_next.dte_speed = st_reg.call_speed[3:0]; // RULE_10
      end else if (mcs_speed_ok(prefix_speed, st_reg.high_baud)) begin
        st_next.dte_speed = prefix_speed; // RULE_06
      end else begin
        st_next.dte_speed = carrier_speed_select[3:0]; // RULE_11
      end
      if (st_reg.baud_phase == 2'd1 && prefix_ambiguous) begin
        st_next.baud_phase = 2'd2; // RULE_07
      end else begin
        st_next.baud_phase = 2'd0; // RULE_07
        st_next.dte_valid  = 1'b1;
      end
    end

    // startup mode load, store and soft reset
    if (nv_load) begin
      st_next.start_mode = nv_rdata; // RULE_13
    end
    if (store_profile) begin
      st_next.nv_store = 1'b1; // RULE_13
      st_next.nv_wdata = st_reg.start_mode;
    end
    if (soft_reset && st_reg.sw_sync) begin
      st_next.op_base   = st_reg.start_mode[1:0]; // RULE_12 RULE_14
      st_next.op_direct = st_reg.start_mode[SM_DIRECT_BIT] && st_reg.start_mode[1:0] != 2'd0; // RULE_15
      st_next.op_ebcdic = st_reg.start_mode[SM_EBCDIC_BIT] && st_reg.start_mode[1]; // RULE_15
    end

    // mode-indicate decode and jack override
    st_next.mi_en     = st_reg.mi_opts[MI_EN_BIT]; // RULE_08
    st_next.mi_edge   = st_reg.mi_opts[MI_EN_BIT] & st_reg.mi_opts[MI_EDGE_BIT];
    st_next.mi_answer = st_reg.mi_opts[MI_EN_BIT] & st_reg.mi_opts[MI_ANSWER_BIT];
    st_next.ring_off  = st_reg.mi_opts[MI_EN_BIT] & st_reg.mi_opts[MI_RING_OFF_BIT];
    st_next.jack_ovr  = (st_reg.mi_opts != 8'h00); // RULE_09

    // result code enables
    st_next.result_en = st_reg.neg_msg[NEG_MSG_BITS-1:0] | result_message_command_mask; // RULE_16 RULE_17 RULE_18

    // automode probe timing
    if (probe_start) begin
      st_next.probe_ticks  = mcs_probe_clamp(st_reg.probe_time); // RULE_19 RULE_21
      st_next.unit_cnt     = 32'h0;
      st_next.probe_send   = answer_mode; // RULE_19
      st_next.probe_reject = ~answer_mode; // RULE_20
    end else if (st_reg.probe_send || st_reg.probe_reject) begin
      if (st_reg.unit_cnt == UNIT_LAST) begin
        st_next.unit_cnt    = 32'h0;
        st_next.probe_ticks = st_reg.probe_ticks - 8'h01;
        if (st_reg.probe_ticks == 8'h01) begin
          st_next.probe_send   = 1'b0;
          st_next.probe_reject = 1'b0; // RULE_20
        end
      end else begin
        st_next.unit_cnt = st_reg.unit_cnt + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg            <= '0;
      st_reg.fail_cause <= RST_FAIL_CAUSE;
      st_reg.high_baud  <= RST_HIGH_BAUD;
      st_reg.mi_opts    <= RST_MI_OPTIONS;
      st_reg.call_speed <= RST_CALL_SPEED;
      st_reg.start_mode <= RST_START_MODE;
      st_reg.neg_msg    <= RST_NEG_MSG; // RULE_16
      st_reg.probe_time <= RST_PROBE_TIME; // RULE_21
      st_reg.dte_speed  <= SPD_9600;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cmd_rvalid               = st_reg.rvalid;
  assign cmd_rerr                 = st_reg.rerr;
  assign cmd_rdata                = st_reg.rdata;
  assign no_carrier               = st_reg.no_carrier;
  assign hang_up                  = st_reg.hang_up;
  assign dte_speed                = st_reg.dte_speed;
  assign dte_speed_valid          = st_reg.dte_valid;
  assign mi_enable                = st_reg.mi_en;
  assign mi_edge                  = st_reg.mi_edge;
  assign mi_answer                = st_reg.mi_answer;
  assign ring_indicator_pulse_off = st_reg.ring_off;
  assign jack_override            = st_reg.jack_ovr;
  assign nv_store                 = st_reg.nv_store;
  assign nv_wdata                 = st_reg.nv_wdata;
  assign op_base_mode             = st_reg.op_base;
  assign op_direct                = st_reg.op_direct;
  assign op_ebcdic                = st_reg.op_ebcdic;
  assign result_enables           = st_reg.result_en;
  assign probe_send               = st_reg.probe_send;
  assign probe_reject             = st_reg.probe_reject;
endmodule // mcs_regs

// file: mcs_regs_asserts.sv
// checker: port-level assertions for the modem config register bank
module mcs_regs_asserts
  import mcs_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       cmd_wr,
  input wire logic       cmd_rd,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_wdata,
  input wire logic       cmd_rvalid,
  input wire logic       cmd_rerr,
  input wire logic       no_carrier,
  input wire logic       hang_up,
  input wire logic       mi_enable,
  input wire logic       mi_edge,
  input wire logic       mi_answer,
  input wire logic       ring_indicator_pulse_off,
  input wire logic       jack_override,
  input wire logic       store_profile,
  input wire logic       nv_store,
  input wire logic [5:0] result_message_command_mask,
  input wire logic [5:0] result_enables,
  input wire logic       probe_start,
  input wire logic       answer_mode,
  input wire logic       probe_send,
  input wire logic       probe_reject
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_mi_wr;
    cmd_wr && cmd_reg == REG_MI_OPTIONS ##1 !(cmd_wr && cmd_reg == REG_MI_OPTIONS);
  endsequence
  sequence s_probe_req;
    probe_start ##1 1'b1;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_rd_answer: assert property (cmd_rd |=> (cmd_rvalid || cmd_rerr))
    else $error("read not answered");
  chk_cause_ro: assert property (cmd_wr && cmd_reg == REG_FAIL_CAUSE |=> cmd_rerr)
    else $error("cause write not refused");
  chk_mi_decode: assert property (s_mi_wr |=> mi_enable == $past(cmd_wdata[0], 2)
    && {ring_indicator_pulse_off, mi_answer, mi_edge} == (mi_enable ? $past(cmd_wdata[3:1], 2) : 3'h0))
    else $error("mode-indicate decode wrong");
  chk_jack_override: assert property (s_mi_wr |=> jack_override == ($past(cmd_wdata, 2) != 8'h00))
    else $error("jack override wrong");
  chk_neg_enables: assert property (!$past(reset) |->
    (($past(result_message_command_mask) & ~result_enables) == 6'h00))
    else $error("command mask not honoured");
  chk_nv_store: assert property (store_profile |=> nv_store)
    else $error("store not issued");
  chk_probe_mode: assert property (s_probe_req |-> probe_send == $past(answer_mode)
    && probe_reject == !$past(answer_mode))
    else $error("probe mode wrong");
  chk_probe_hold: assert property ($rose(probe_send) |-> probe_send [*8])
    else $error("probe too short");
  chk_hang_pulse: assert property (hang_up |-> no_carrier ##1 !hang_up)
    else $error("hang-up pulse wrong");
endmodule // mcs_regs_asserts

bind mcs_regs mcs_regs_asserts i_chk (.clk, .reset, .cmd_wr, .cmd_rd, .cmd_reg, .cmd_wdata, .cmd_rvalid, .cmd_rerr,
  .no_carrier, .hang_up, .mi_enable, .mi_edge, .mi_answer, .ring_indicator_pulse_off, .jack_override, .store_profile,
  .nv_store, .result_message_command_mask, .result_enables, .probe_start, .answer_mode, .probe_send, .probe_reject);

// file: mcs_regs_test.sv
// testbench: host command scenarios for the modem config register bank
module mcs_regs_test;
  import mcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint PU = 4;
  logic clk, reset, cmd_wr, cmd_rd, cmd_rvalid, cmd_rerr, call_start, fail_event, sync_activity;
  logic msg_retransmit, msg_acked, no_carrier, hang_up, autobaud_start, prefix_char, prefix_ambiguous;
  logic dte_speed_valid, mi_enable, mi_edge, mi_answer, ring_off, jack_override, std_switch_pin, soft_reset;
  logic nv_load, store_profile, nv_store, op_direct, op_ebcdic, probe_start, answer_mode, probe_send, probe_reject;
  logic [7:0] cmd_reg, cmd_wdata, cmd_rdata, fail_code, carrier_speed_select, nv_rdata, nv_wdata, d;
  logic [3:0] prefix_speed, dte_speed;
  logic [1:0] op_base_mode;
  logic [5:0] mask, result_enables;
  logic       e;
  int         n_mismatch, samples_checked, k, i;
  logic [7:0] rl[7] = '{REG_FAIL_CAUSE, REG_HIGH_BAUD, REG_MI_OPTIONS, REG_CALL_SPEED, REG_START_MODE,
                        REG_NEG_MSG, REG_PROBE_TIME};
  logic [7:0] rv[7] = '{8'h00, RST_HIGH_BAUD, 8'h00, RST_CALL_SPEED, 8'h00, 8'h00, 8'h1e};
  logic [7:0] codes[7] = '{8'h00, 8'h04, 8'h05, 8'h0a, 8'h0c, 8'h0e, 8'h0f};
  logic [7:0] modes[6] = '{8'h00, 8'h01, 8'h06, 8'h07, 8'h0c, 8'h0b};
  logic [7:0] mexp[6] = '{8'h00, 8'h04, 8'h0a, 8'h0e, 8'h00, 8'h0d};

  mcs_host_model i_host (.clk, .cmd_wr, .cmd_rd, .cmd_reg, .cmd_wdata, .cmd_rvalid, .cmd_rerr, .cmd_rdata);
  mcs_regs #(.NO_SYNC_CYCLES_P(20), .PROBE_UNIT_P(PU)) i_dut (.clk, .reset, .cmd_wr, .cmd_rd, .cmd_reg, .cmd_wdata,
    .cmd_rvalid, .cmd_rerr, .cmd_rdata, .call_start, .fail_event, .fail_code, .sync_activity, .msg_retransmit,
    .msg_acked, .no_carrier, .hang_up, .autobaud_start, .prefix_char, .prefix_speed, .prefix_ambiguous,
    .carrier_speed_select, .dte_speed, .dte_speed_valid, .mi_enable, .mi_edge, .mi_answer,
    .ring_indicator_pulse_off(ring_off), .jack_override, .std_switch_pin, .soft_reset, .nv_load, .nv_rdata,
    .store_profile, .nv_store, .nv_wdata, .op_base_mode, .op_direct, .op_ebcdic, .result_message_command_mask(mask),
    .result_enables, .probe_start, .answer_mode, .probe_send, .probe_reject);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] r, input logic [7:0] exp);
    i_host.rd(r, d, e);
    check(d, exp);
    check({7'h0, e}, 8'h00);
  endtask
  task automatic wait_for(input int sel);
    logic [3:0] w;
    for (k = 0; k < 100; k++) begin
      w = {~(probe_send | probe_reject), probe_send | probe_reject, dte_speed_valid, hang_up};
      if (w[sel] === 1'b1) return;
      @(negedge clk);
    end
    n_mismatch++;
    $display("Error at %0t: wait timed out", $time);
    results();
  endtask
  task automatic start_call;
    @(negedge clk) call_start = 1'b1;
    @(negedge clk) call_start = 1'b0;
  endtask
  task automatic ab(input logic [3:0] s1, input logic amb, input logic [3:0] s2, input logic [3:0] exp);
    @(negedge clk) autobaud_start = 1'b1;
    @(negedge clk) autobaud_start = 1'b0;
    {prefix_char, prefix_speed, prefix_ambiguous} = {1'b1, s1, amb};
    if (amb) begin
      @(negedge clk) {prefix_char, prefix_speed, prefix_ambiguous} = {1'b1, s2, 1'b0};
    end
    @(negedge clk) prefix_char = 1'b0;
    wait_for(1);
    check({4'h0, dte_speed}, {4'h0, exp});
  endtask
  task automatic probe(input logic a, input logic [7:0] v);
    i_host.wr(REG_PROBE_TIME, v, e);
    @(negedge clk) {probe_start, answer_mode} = {1'b1, a};
    @(negedge clk) probe_start = 1'b0;
    wait_for(2);
    check(8'({probe_send, probe_reject}), 8'({a, !a}));
    wait_for(3);
    check(8'(k), 8'(15 * PU));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {reset, call_start, fail_event, msg_retransmit, msg_acked, autobaud_start, prefix_char} = 7'h40;
    {prefix_ambiguous, soft_reset, nv_load, store_profile, probe_start, answer_mode} = 6'h00;
    {fail_code, nv_rdata, carrier_speed_select, prefix_speed, mask} = {8'h00, 8'h00, 8'h07, 4'h0, 6'h00};
    {sync_activity, std_switch_pin, n_mismatch, samples_checked} = {2'b11, 32'd0, 32'd0};
    repeat (16) @(negedge clk);
    reset = 1'b0;
    for (i = 0; i < 7; i++) rdchk(rl[i], rv[i]);
    i_host.rd(8'h55, d, e);
    check({d[7:1], e}, 8'h01);
    i_host.wr(REG_FAIL_CAUSE, 8'h07, e);
    check({7'h0, e}, 8'h01);
    $display("test register map done");
    i_host.wr(REG_MI_OPTIONS, 8'h0d, e);
    @(negedge clk);
    check({3'h0, mi_enable, mi_edge, mi_answer, ring_off, jack_override}, 8'h17);
    i_host.wr(REG_MI_OPTIONS, 8'h00, e);
    @(negedge clk);
    check({3'h0, mi_enable, mi_edge, mi_answer, ring_off, jack_override}, 8'h00);
    $display("test mode-indicate done");
    start_call();
    msg_retransmit = 1'b1;
    repeat (9) @(negedge clk);
    {msg_retransmit, msg_acked} = 2'b01;
    @(negedge clk) {msg_retransmit, msg_acked} = 2'b10;
    repeat (10) @(negedge clk);
    msg_retransmit = 1'b0;
    wait_for(0);
    check({7'h0, no_carrier}, 8'h01);
    {fail_event, fail_code} = {1'b1, 8'h04};
    @(negedge clk) fail_event = 1'b0;
    rdchk(REG_FAIL_CAUSE, CAUSE_NO_REPLY);
    for (i = 0; i < 7; i++) begin
      start_call();
      {fail_event, fail_code} = {1'b1, codes[i]};
      @(negedge clk) fail_code = 8'h0e;
      check({7'h0, hang_up}, 8'h01);
      @(negedge clk) fail_event = 1'b0;
      rdchk(REG_FAIL_CAUSE, codes[i]);
    end
    sync_activity = 1'b0;
    start_call();
    wait_for(0);
    sync_activity = 1'b1;
    rdchk(REG_FAIL_CAUSE, CAUSE_NO_SYNC);
    $display("test failure cause done");
    ab(4'h9, 1'b0, 4'h0, 4'h9);
    ab(4'hc, 1'b0, 4'h0, 4'hc);
    ab(4'hd, 1'b0, 4'h0, 4'h7);
    i_host.wr(REG_HIGH_BAUD, HIGH_SEL_38400, e);
    ab(4'hd, 1'b0, 4'h0, 4'hd);
    ab(4'h5, 1'b1, 4'hc, 4'h7);
    i_host.wr(REG_START_MODE, 8'h01, e);
    i_host.wr(REG_CALL_SPEED, 8'h0b, e);
    ab(4'h9, 1'b0, 4'h0, 4'hb);
    $display("test autobaud done");
    for (i = 0; i < 6; i++) begin
      i_host.wr(REG_START_MODE, modes[i], e);
      @(negedge clk) soft_reset = 1'b1;
      @(negedge clk) soft_reset = 1'b0;
      @(negedge clk);
      check({4'h0, op_base_mode, op_direct, op_ebcdic}, mexp[i]);
    end
    std_switch_pin = 1'b0;
    i_host.wr(REG_START_MODE, 8'h02, e);
    @(negedge clk) soft_reset = 1'b1;
    @(negedge clk) soft_reset = 1'b0;
    @(negedge clk);
    check({4'h0, op_base_mode, op_direct, op_ebcdic}, 8'h0d);
    @(negedge clk) store_profile = 1'b1;
    @(negedge clk) store_profile = 1'b0;
    check({7'h0, nv_store}, 8'h01);
    check(nv_wdata, 8'h02);
    {nv_rdata, nv_load, std_switch_pin} = {8'h05, 2'b11};
    @(negedge clk) nv_load = 1'b0;
    rdchk(REG_START_MODE, 8'h05);
    $display("test startup mode done");
    i_host.wr(REG_NEG_MSG, 8'h24, e);
    mask = 6'h01;
    repeat (2) @(negedge clk);
    check({2'h0, result_enables}, 8'h25);
    rdchk(REG_NEG_MSG, 8'h24);
    mask = 6'h00;
    repeat (2) @(negedge clk);
    check({2'h0, result_enables}, 8'h24);
    $display("test negotiation messages done");
    probe(1'b1, 8'h0f);
    probe(1'b0, 8'h05);
    @(negedge clk) reset = 1'b1;
    @(negedge clk) reset = 1'b0;
    rdchk(REG_PROBE_TIME, 8'h1e);
    $display("test probe timing done");
    results();
  end
endmodule // mcs_regs_test
